/* File: hdl/pdt_edge_sync.sv */
/*
 * pdt_edge_sync: two-flop synchroniser for the timer pin plus rising-edge detect.
 * assumes the pin is asynchronous to clk_sys; edges narrower than ~2 cycles may be lost.
 */
module pdt_edge_sync (
    input  wire logic clk_sys,     // system clock
    input  wire logic reset_n,     // synchronous reset, active low
    input  wire logic pin_async,   // raw pin level
    output logic      pin_level,   // synchronised level
    output logic      pin_rise     // one-cycle pulse on rising edge
);
    logic stage1;
    logic stage2;
    logic stage3;

    // first flop is read only by the second
    // reset to the pulled-up idle level, so releasing reset makes no false rising edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= pin_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign pin_level = stage2;
    assign pin_rise  = stage2 & ~stage3;
endmodule

/* File: hdl/pdt_pkg.sv */
/*
 * pdt_pkg: constants and carrier types for the prescaled down-counter timer.
 * assumes a single 200 MHz system clock and a byte-wide register port.
 */
package pdt_pkg;
    // register offsets
    localparam logic [7:0] PDT_ADDR_PRESCALER = 8'hD2;
    localparam logic [7:0] PDT_ADDR_COUNT     = 8'hD3;
    localparam logic [7:0] PDT_ADDR_STATUS    = 8'hD4;
    localparam logic [7:0] PDT_ADDR_IRQ_STAT  = 8'hD5;
    localparam logic [7:0] PDT_ADDR_IRQ_CLR   = 8'hD6;
    localparam logic [7:0] PDT_ADDR_IRQ_EN    = 8'hD7;
    localparam logic [7:0] PDT_ADDR_LOWPOWER  = 8'hD8;
    // status/control field positions
    localparam int PDT_BIT_ZERO    = 7;
    localparam int PDT_BIT_IRQ_EN  = 6;
    localparam int PDT_BIT_PIN_DIR = 5;
    localparam int PDT_BIT_DOUT    = 4;
    localparam int PDT_BIT_RUN     = 3;
    // reset values, and the count at which a tick underflows
    localparam logic [6:0] PDT_PRESCALER_RESET = 7'h7F;
    localparam logic [7:0] PDT_COUNT_RESET     = 8'hFF;
    localparam logic [7:0] PDT_STATUS_RESET    = 8'h00;
    localparam logic [7:0] PDT_NO_UNDERFLOW    = 8'h00;
    // internal clock divided by 12 feeds the prescaler
    localparam int         PDT_INT_DIV       = 12;
    localparam logic [3:0] PDT_INT_DIV_LAST  = 4'(PDT_INT_DIV - 1);

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pdt_bus_req_type;

    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
    } pdt_pin_drive_type;
endpackage

/* File: hdl/pdt_timer.sv */
/*
 * pdt_timer: 8-bit down-counter with a 7-bit prescaler, zero flag, interrupt and timer pin.
 * assumes a byte register port (read data one cycle after the read strobe) on clk_sys.
 */
module pdt_timer (
    input  wire logic                       clk_sys,     // 200 MHz system clock
    input  wire logic                       reset_n,     // synchronous reset, active low
    input  wire logic [7:0]                 reg_addr,    // register address
    input  wire logic [7:0]                 reg_wdata,   // register write data
    input  wire logic                       reg_wr,      // write strobe
    input  wire logic                       reg_rd,      // read strobe
    output logic      [7:0]                 reg_rdata,   // read data, cycle after strobe
    input  wire logic                       stop_mode,   // core is in stop mode
    input  wire logic                       pin_in,      // timer pin input level
    output logic                            pin_out,     // timer pin output level
    output logic                            pin_oe_n,    // pin output enable, low drives
    output pdt_pkg::pdt_pin_drive_type      pin_drive,   // pin drive bundle
    output logic                            timer_irq,   // legacy zero request level
    output logic                            wake_req,    // wake request to core
    output logic                            irq          // status/enable interrupt level
);
    import pdt_pkg::*;

    pdt_bus_req_type req;
    logic [6:0] prescaler;
    logic [7:0] count;
    logic [7:0] ctrl;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    logic       zero_flag_q;
    logic [3:0] div12_cnt;
    logic       div12_tick;
    logic       pin_level;
    logic       pin_rise;
    logic       pre_tick;
    logic       count_tick;
    logic [6:0] next_prescaler;
    logic       underflow;
    logic       wr_count;
    logic       wr_status;
    logic       wr_prescaler;
    logic       zero_rise;
    logic       pin_latch;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    wire zero_flag           = ctrl[PDT_BIT_ZERO];
    wire zero_irq_enable     = ctrl[PDT_BIT_IRQ_EN];
    wire pin_direction_select = ctrl[PDT_BIT_PIN_DIR];
    wire data_out            = ctrl[PDT_BIT_DOUT];
    wire prescaler_run       = ctrl[PDT_BIT_RUN];
    wire [2:0] divide_select = ctrl[2:0];

    assign wr_count     = req.wr && (req.addr == PDT_ADDR_COUNT);
    assign wr_status    = req.wr && (req.addr == PDT_ADDR_STATUS);
    assign wr_prescaler = req.wr && (req.addr == PDT_ADDR_PRESCALER);

    pdt_edge_sync u_pin_sync (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .pin_async (pin_in),
        .pin_level (pin_level),
        .pin_rise  (pin_rise)
    );

    // internal clock divided by 12; cleared and held at zero in stop mode since the core clock is gone
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            div12_cnt <= 4'h0;
        end else if (div12_tick || stop_mode) begin
            div12_cnt <= 4'h0;
        end else begin
            div12_cnt <= div12_cnt + 4'h1;
        end
    end
    assign div12_tick = (div12_cnt == PDT_INT_DIV_LAST) && !stop_mode;

    // prescaler clock source select
    // the pin is read only through the synchroniser; its raw level may be metastable
    always_comb begin
        if (pin_direction_select) begin
            pre_tick = div12_tick;
        end else if (data_out) begin
            pre_tick = div12_tick & pin_level;          // gated mode
        end else begin
            pre_tick = pin_rise;                        // event count, runs in stop too
        end
        pre_tick = pre_tick & prescaler_run;
    end

    // tap: counter ticks when the low n prescaler bits wrap, i.e. input divided by 2^n
    always_comb begin
        next_prescaler = (prescaler == 7'h00) ? PDT_PRESCALER_RESET : prescaler - 7'h01;
        count_tick = pre_tick;
        for (int b = 0; b < 7; b++) begin
            if (b < int'(divide_select)) begin
                count_tick = count_tick & (prescaler[b] == 1'b0);
            end
        end
    end

    // prescaler: held at 7Fh when not running, direct write allowed while running
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prescaler <= PDT_PRESCALER_RESET;
        end else if (!prescaler_run) begin
            prescaler <= PDT_PRESCALER_RESET;
        end else if (wr_prescaler) begin
            prescaler <= req.wdata[6:0];
        end else if (pre_tick) begin
            prescaler <= next_prescaler;
        end
    end

    assign underflow = count_tick && (count == PDT_NO_UNDERFLOW) && !wr_count;

    // counter: software write wins over a decrement
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= PDT_COUNT_RESET;
        end else if (wr_count) begin
            count <= req.wdata;
        end else if (count_tick) begin
            count <= count - 8'h01;                     // wraps 00h to FFh
        end
    end

    // control register; zero flag set by hardware wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl <= PDT_STATUS_RESET;
        end else begin
            if (wr_status) begin
                ctrl[6:0] <= req.wdata[6:0];
                ctrl[PDT_BIT_ZERO] <= req.wdata[7] | underflow;
            end else if (underflow) begin
                ctrl[PDT_BIT_ZERO] <= 1'b1;
            end
        end
    end

    // flag edge detect for the output latch
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            zero_flag_q <= 1'b0;
        end else begin
            zero_flag_q <= zero_flag;
        end
    end
    assign zero_rise = zero_flag & ~zero_flag_q;

    // pin latch captures data-out on each flag rise; reads as input until direction set
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_latch <= 1'b0;
        end else if (zero_rise) begin
            pin_latch <= data_out;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out  <= pin_latch;
            pin_oe_n <= ~pin_direction_select;
        end
    end
    assign pin_drive = '{pin_out: pin_out, pin_oe_n: pin_oe_n};

    // request level and wake-up
    assign timer_irq = zero_flag & zero_irq_enable;
    assign wake_req  = timer_irq;

    // sticky event status: bit0 underflow, bit1 pin edge; set beats clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_status <= 8'h00;
            irq_enable <= 8'h00;
        end else begin
            if (req.wr && req.addr == PDT_ADDR_IRQ_EN) begin
                irq_enable <= {6'h00, req.wdata[1:0]};
            end
            irq_status <= ((req.wr && req.addr == PDT_ADDR_IRQ_CLR) ? (irq_status & ~req.wdata) : irq_status)
                          | {6'h00, pin_rise, underflow};
        end
    end
    assign irq = |(irq_status & irq_enable);

    // register map seen by software:
    //   D2h prescaler count, bit 7 always reads zero
    //   D3h down-counter, readable and writable on the fly
    //   D4h status and control: zero flag, enable, direction, data-out, run, divide
    //   D5h sticky event status, read only
    //   D6h event clear, write ones; reads back as 00h
    //   D7h event enable, bits 1:0 only
    //   D8h stop-mode indication, read only
    // limitation: D6h is not readable, so a read-modify-write of it clears nothing useful
    // read data registered one cycle after the strobe; unmapped reads give 00h
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                PDT_ADDR_PRESCALER: reg_rdata <= {1'b0, prescaler};
                PDT_ADDR_COUNT:     reg_rdata <= count;
                PDT_ADDR_STATUS:    reg_rdata <= ctrl;
                PDT_ADDR_IRQ_STAT:  reg_rdata <= irq_status;
                PDT_ADDR_IRQ_EN:    reg_rdata <= irq_enable;
                PDT_ADDR_LOWPOWER:  reg_rdata <= {7'h00, stop_mode};
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    a_zero_on_underflow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        underflow |=> zero_flag && count == PDT_COUNT_RESET)
        else $error("zero flag or reload missing after underflow");
    a_flag_stays_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        zero_flag && !wr_status |=> zero_flag)
        else $error("zero flag cleared without a write");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        underflow && zero_irq_enable && !wr_status |=> timer_irq)
        else $error("no timer request after an enabled underflow");
    a_prescaler_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.rd && req.addr == PDT_ADDR_PRESCALER |=> reg_rdata == {1'b0, $past(prescaler)})
        else $error("prescaler read wrong");
    a_count_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_count |=> count == $past(req.wdata) && !$rose(zero_flag))
        else $error("count write lost or flagged");
    a_reset_values: assert property (@(posedge clk_sys)
        !reset_n |=> ctrl == PDT_STATUS_RESET && count == PDT_COUNT_RESET)
        else $error("reset values wrong");
    a_pin_direction: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 pin_oe_n == !$past(pin_direction_select))
        else $error("pin enable does not follow direction");
    a_pin_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        zero_rise |=> ##1 pin_out == $past(data_out, 2))
        else $error("data-out not transferred on flag rise");
    a_hold_stopped: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !prescaler_run && !wr_count |=> prescaler == PDT_PRESCALER_RESET && $stable(count))
        else $error("timer moved while stopped");
    a_count_decrement: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count_tick && !wr_count |=> count == $past(count) - 8'h01)
        else $error("counter did not decrement");

    // zero flag: only an underflow or a software set raises it; a clear never hides an underflow
    a_flag_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(zero_flag) |->
        $past(underflow) || $past(wr_status))
        else $error("zero flag rose without underflow or write");
    a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        underflow && wr_status |=>
        zero_flag)
        else $error("software clear hid an underflow");
    a_irq_disabled: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_status && !req.wdata[PDT_BIT_IRQ_EN] |=>
        !timer_irq)
        else $error("timer request with enable written low");

    // read path: the count comes back as it stood at the strobe
    a_count_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.rd && req.addr == PDT_ADDR_COUNT |=>
        reg_rdata == $past(count))
        else $error("count read wrong");

    // pin latch moves only on a flag rise, and the pin follows two cycles later
    a_latch_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !zero_rise |=>
        $stable(pin_latch))
        else $error("pin latch moved without a flag rise");
    a_pin_change: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $changed(pin_out) |->
        $past(zero_rise, 2))
        else $error("pin level changed without a flag rise");

    // prescaler steps down by one per tick, reloads after zero, and never ticks while held
    a_prescaler_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pre_tick && !wr_prescaler && prescaler != 7'h00 |=>
        prescaler == $past(prescaler) - 7'h01)
        else $error("prescaler did not step down");
    a_prescaler_reload: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pre_tick && !wr_prescaler && prescaler == 7'h00 |=>
        prescaler == PDT_PRESCALER_RESET)
        else $error("prescaler did not reload after zero");
    a_no_tick_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !prescaler_run |->
        !pre_tick && !count_tick)
        else $error("tick while the run bit is clear");

    // tap: divide by one passes every tick, by two needs an even count, by 128 a wrap
    a_tap_div1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pre_tick && divide_select == 3'h0 |->
        count_tick)
        else $error("divide by one dropped a tick");
    a_tap_div2: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count_tick && divide_select == 3'h1 |->
        !prescaler[0])
        else $error("divide by two ticked on an odd count");
    a_tap_div128: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count_tick && divide_select == 3'h7 |->
        prescaler == 7'h00)
        else $error("divide by 128 ticked before the wrap");

    // clock source per pin mode; stop freezes everything but event counting
    a_internal_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pin_direction_select && prescaler_run |->
        pre_tick == div12_tick)
        else $error("output mode not clocked by the divided clock");
    a_gate_closed: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !pin_direction_select && data_out && !pin_level |->
        !pre_tick)
        else $error("gated mode ticked with the pin low");
    a_event_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !pin_direction_select && !data_out && prescaler_run && pin_rise |->
        pre_tick)
        else $error("event mode missed a pin edge");
    a_stop_frozen: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stop_mode && (pin_direction_select || data_out) |->
        !pre_tick)
        else $error("divided clock ticked in stop mode");
    a_stop_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stop_mode && pin_direction_select && !wr_count |=>
        $stable(count))
        else $error("counter moved in stop mode");
endmodule

/* File: test/pdt_pin_model.sv */
/*
 * pdt_pin_model: far end of the timer pin, a pulled-up signal source or load.
 * assumes the bench sets src_level; the device drive wins while pin_oe_n is low.
 */
module pdt_pin_model (
    input  wire logic pin_out,    // device drive level
    input  wire logic pin_oe_n,   // device enable, low drives
    input  wire logic src_level,  // level the external source applies
    output logic      pin_wire    // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // push-pull drive overrides the source; a released pin follows the source, idling at the pull-up
    assign pin_wire = pin_oe_n ? src_level : pin_out;
endmodule

/* File: test/prescaled_downcounter_timer_regs_tb.sv */
/*
 * prescaled_downcounter_timer_regs_tb: self-checking bench for pdt_timer.
 * assumes a 200 MHz clock, synchronous low reset and the pin model as far end.
 */
module prescaled_downcounter_timer_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pdt_pkg::*;
    logic                clk_sys, reset_n, reg_wr, reg_rd, stop_mode, src_level, pin_in;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata, v;
    logic                pin_out, pin_oe_n, timer_irq, wake_req, irq;
    pdt_pin_drive_type   pin_drive;
    int                  errors, n_checks;

    pdt_timer i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_drive(pin_drive), .timer_irq(timer_irq),
        .wake_req(wake_req), .irq(irq));
    pdt_pin_model i_pin (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .src_level(src_level), .pin_wire(pin_in));

    // clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // one comparison; tasks are entered just after a rising edge
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    // one-cycle write strobe, then an idle edge so strobes never collide in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // read data stand only in the cycle after the strobe, taken at the closing edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic t_reset_values();
        rd(PDT_ADDR_PRESCALER, v); chk("prescaler reset", 8'h7F, v);
        rd(PDT_ADDR_COUNT, v);     chk("count reset", 8'hFF, v);
        rd(PDT_ADDR_STATUS, v);    chk("status reset", 8'h00, v);
        chk("oe_n reset", 8'h01, {7'h00, pin_oe_n});
        rd(8'hD9, v);              chk("unmapped read", 8'h00, v);
        rd(PDT_ADDR_IRQ_STAT, v);  chk("no reset edge", 8'h00, v);
        wr(PDT_ADDR_PRESCALER, 8'h10);
        rd(PDT_ADDR_PRESCALER, v); chk("prescaler held", 8'h7F, v);
        wr(PDT_ADDR_COUNT, 8'h5A); repeat (40) @(posedge clk_sys);
        rd(PDT_ADDR_COUNT, v);     chk("count frozen", 8'h5A, v);
    endtask

    // underflow from 01h in output mode, flag stickiness, both interrupt paths
    task automatic t_underflow();
        int k;
        wr(PDT_ADDR_COUNT, 8'h01);
        wr(PDT_ADDR_STATUS, 8'h68);
        chk("irq before", 8'h00, {7'h00, timer_irq});
        for (k = 0; k < 100 && timer_irq !== 1'b1; k++) @(posedge clk_sys);
        chk("irq on underflow", 8'h01, {7'h00, timer_irq});
        chk("wake", 8'h01, {7'h00, wake_req});
        repeat (40) @(posedge clk_sys);
        rd(PDT_ADDR_STATUS, v);    chk("flag sticky", 8'hE8, v);
        rd(PDT_ADDR_IRQ_STAT, v);  chk("event status", 8'h01, v & 8'h01);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(PDT_ADDR_IRQ_EN, 8'h01); chk("irq enabled", 8'h01, {7'h00, irq});
        wr(PDT_ADDR_IRQ_CLR, 8'h01); chk("irq cleared", 8'h00, {7'h00, irq});
        rd(PDT_ADDR_IRQ_STAT, v);  chk("event cleared", 8'h00, v & 8'h01);
        wr(PDT_ADDR_STATUS, 8'h68); chk("flag cleared", 8'h00, {7'h00, timer_irq});
        wr(PDT_ADDR_STATUS, 8'hA8); chk("no enable", 8'h00, {7'h00, timer_irq});
        wr(PDT_ADDR_STATUS, 8'hE8); chk("enable on", 8'h01, {7'h00, timer_irq});
    endtask

    // data-out reaches the pin only when the flag rises
    task automatic t_output_pin();
        int k;
        wr(PDT_ADDR_STATUS, 8'h00);
        wr(PDT_ADDR_COUNT, 8'h00);
        wr(PDT_ADDR_STATUS, 8'h38);
        @(posedge clk_sys); // the enable is registered one cycle behind the direction bit
        chk("pin before", 8'h00, {7'h00, pin_out});
        chk("pin driven", 8'h00, {7'h00, pin_oe_n});
        for (k = 0; k < 60 && v[7] !== 1'b1; k++) rd(PDT_ADDR_STATUS, v);
        repeat (4) @(posedge clk_sys);
        chk("pin latched", 8'h01, {7'h00, pin_out});
        chk("pin bundle", 8'h02, {6'h00, pin_drive});
    endtask

    // pin rising edges clock the prescaler; gated mode needs the pin high
    task automatic t_event_gated();
        wr(PDT_ADDR_STATUS, 8'h00);
        wr(PDT_ADDR_COUNT, 8'h10);
        wr(PDT_ADDR_STATUS, 8'h08);
        wr(PDT_ADDR_IRQ_CLR, 8'h02);
        repeat (3) begin
            src_level <= 1'b0; repeat (4) @(posedge clk_sys);
            src_level <= 1'b1; repeat (4) @(posedge clk_sys);
        end
        rd(PDT_ADDR_PRESCALER, v); chk("events prescaler", 8'h7C, v);
        rd(PDT_ADDR_COUNT, v);     chk("events count", 8'h0D, v);
        rd(PDT_ADDR_IRQ_STAT, v);  chk("edge event", 8'h02, v & 8'h02);
        src_level <= 1'b0; // low level must pass the synchroniser before the gate opens
        wr(PDT_ADDR_STATUS, 8'h00);
        wr(PDT_ADDR_STATUS, 8'h18); repeat (40) @(posedge clk_sys);
        rd(PDT_ADDR_PRESCALER, v); chk("gate closed", 8'h7F, v);
        src_level <= 1'b1; repeat (40) @(posedge clk_sys);
        rd(PDT_ADDR_PRESCALER, v); chk("gate open", 8'h01, {7'h00, v < 8'h7F});
        stop_mode <= 1'b1;
        wr(PDT_ADDR_STATUS, 8'h00);
        wr(PDT_ADDR_STATUS, 8'h28); repeat (60) @(posedge clk_sys);
        rd(PDT_ADDR_PRESCALER, v); chk("stop frozen", 8'h7F, v);
        rd(PDT_ADDR_LOWPOWER, v);  chk("stop visible", 8'h01, v);
        wr(PDT_ADDR_STATUS, 8'h00);
        wr(PDT_ADDR_STATUS, 8'h08);
        src_level <= 1'b0; repeat (4) @(posedge clk_sys);
        src_level <= 1'b1; repeat (4) @(posedge clk_sys);
        rd(PDT_ADDR_PRESCALER, v); chk("stop events", 8'h7E, v);
        stop_mode <= 1'b0;
    endtask

    // about four divided ticks per code: a wrong tap lands far outside 3 to 5
    task automatic t_divide();
        int n;
        for (n = 0; n < 8; n++) begin
            wr(PDT_ADDR_STATUS, 8'h00);
            wr(PDT_ADDR_COUNT, 8'hFF);
            wr(PDT_ADDR_STATUS, 8'h28 | 8'(n));
            repeat (48 << n) @(posedge clk_sys);
            wr(PDT_ADDR_STATUS, 8'h00);
            rd(PDT_ADDR_COUNT, v);
            chk("divide ticks", 8'h01, {7'h00, (8'hFF - v) >= 8'd3 && (8'hFF - v) <= 8'd5});
        end
    endtask

    task automatic summarize();
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the roughly 13k cycles the tests need
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        summarize();
    end

    initial begin
        errors = 0; n_checks = 0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 8'h00; stop_mode = 1'b0; src_level = 1'b1; v = 8'h00;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset_values();
        t_underflow();
        t_output_pin();
        t_event_gated();
        t_divide();
        summarize();
    end
endmodule
